// [verilog/pph_pkg.sv]
/*
 * pph_pkg: constants, field layout and state struct of the profile position
 * set-point handshake.
 * assumes: object dictionary access and motion feedback share the control clock.
 */
package pph_pkg;

    // object dictionary indices
    localparam logic [15:0] IDX_ERROR_CODE  = 16'h603F;
    localparam logic [15:0] IDX_CONTROL     = 16'h6040;
    localparam logic [15:0] IDX_STATUS      = 16'h6041;
    localparam logic [15:0] IDX_MODE_SEL    = 16'h6060;
    localparam logic [15:0] IDX_MODE_DISP   = 16'h6061;
    localparam logic [15:0] IDX_POS_CMD     = 16'h6062;
    localparam logic [15:0] IDX_POS_FB      = 16'h6063;
    localparam logic [15:0] IDX_POS_ACT     = 16'h6064;
    localparam logic [15:0] IDX_FE_LIMIT    = 16'h6065;
    localparam logic [15:0] IDX_BAND        = 16'h6067;
    localparam logic [15:0] IDX_DWELL       = 16'h6068;
    localparam logic [15:0] IDX_VEL_ACT     = 16'h606C;
    localparam logic [15:0] IDX_TORQUE_ACT  = 16'h6077;
    localparam logic [15:0] IDX_TARGET      = 16'h607A;
    localparam logic [15:0] IDX_MOVE_VEL    = 16'h6081;
    localparam logic [15:0] IDX_ACCEL       = 16'h6083;
    localparam logic [15:0] IDX_DECEL       = 16'h6084;
    localparam logic [15:0] IDX_GEAR        = 16'h6091;
    localparam logic [15:0] IDX_TQ_FWD      = 16'h60E0;
    localparam logic [15:0] IDX_TQ_REV      = 16'h60E1;
    localparam logic [15:0] IDX_DEVIATION   = 16'h60F4;
    localparam logic [7:0]  SUB_GEAR_NUM    = 8'h01;
    localparam logic [7:0]  SUB_GEAR_DEN    = 8'h02;

    // control word bits
    localparam int CW_RUN_LSB    = 0;
    localparam int CW_RUN_MSB    = 3;
    localparam int CW_NEW_SP     = 4;
    localparam int CW_IMMEDIATE  = 5;
    localparam int CW_RELATIVE   = 6;
    localparam logic [3:0] CW_RUN_ALL = 4'hF;

    // status word bits and state patterns
    localparam int SW_REACHED    = 10;
    localparam int SW_SP_ACK     = 12;
    localparam int SW_FOLLOW_ERR = 13;
    localparam logic [15:0] SW_OP_ENABLED = 16'h0237;
    localparam logic [15:0] SW_READY      = 16'h0231;
    localparam logic [15:0] SW_IDLE       = 16'h0250;

    localparam logic [15:0] ALARM_NONE   = 16'h0000;
    localparam logic [15:0] ALARM_FOLLOW = 16'h0009;

    // reset values
    localparam logic [15:0] RST_CTRL    = 16'h0000;
    localparam logic [15:0] RST_MODE    = 16'h0000;
    localparam logic [15:0] RST_FE_LIM  = 16'h7D00;
    localparam logic [31:0] RST_BAND    = 32'h0000_000A;
    localparam logic [15:0] RST_DWELL   = 16'h0000;
    localparam logic [31:0] RST_TARGET  = 32'h0000_0000;
    localparam logic [15:0] RST_VEL     = 16'h0000;
    localparam logic [15:0] RST_RAMP    = 16'h0064;
    localparam logic [31:0] RST_GNUM    = 32'h0000_0000;
    localparam logic [31:0] RST_GDEN    = 32'h0000_2710;
    localparam logic [15:0] RST_TORQUE  = 16'h0064;

    // dwell time base
    localparam int CLK_PERIOD_NS = 4;
    localparam int DWELL_UNIT_MS = 1;
    localparam int NS_PER_MS     = 1000000;
    localparam int MS_CYCLES     = DWELL_UNIT_MS * NS_PER_MS / CLK_PERIOD_NS;

    typedef struct packed {
        logic [31:0] target;
        logic [15:0] vel;
        logic [15:0] acc;
        logic [15:0] dec;
    } pph_setpoint_s;

    typedef struct packed {
        logic [15:0]   ctrl;
        logic [15:0]   mode;
        logic [15:0]   fe_lim;
        logic [31:0]   band;
        logic [15:0]   dwell;
        logic [31:0]   gnum;
        logic [31:0]   gden;
        logic [15:0]   tq_fwd;
        logic [15:0]   tq_rev;
        pph_setpoint_s host_sp;
        pph_setpoint_s act_sp;
        logic          nsp_prev;
        logic          sp_ack;
        logic          start;
        logic          reached;
        logic          follow_err;
        logic [31:0]   ms_cnt;
        logic [15:0]   dwell_cnt;
        logic [31:0]   dev;
        logic [15:0]   status;
        logic [15:0]   err_code;
        logic          run;
        logic [31:0]   rdata;
        logic          rack;
    } pph_state_s;

endpackage : pph_pkg

// [verilog/pph_top.sv]
/*
 * pph_top: profile position set-point handshake, control word decode,
 * status word, target reached dwell and following error detection.
 * assumes: object dictionary requests and motion feedback come from logic
 * on mclk_i; the path generator drives pg_busy_i while a move is under way.
 */
// Operation
// - drive runs only when control word bits 0 to 3 are all one
// - rising edge of bit 4 starts a move, capturing target and profile
// - bit 5 chooses deferred (0) or immediate (1) set-point change
// - bit 6 chooses absolute (0) or relative (1) target
// - status bit 10 is one when target reached, else zero
// - status bit 12 acknowledges a taken set-point, zero while waiting
// - status bit 13 is one while following error present
// - reached set when deviation within band for the dwell time
// - reached output drops whenever band condition fails; raising dwell afterwards keeps it set
// - deviation above following window shows alarm 9 and bit 13
// - immediate mode executes new set-point at once and raises acknowledge
// - immediate mode clears acknowledge when bit 4 falls
// - immediate relative keeps unfinished move; travel sums both increments
// - immediate absolute ends solely at the newest target
// - deferred mode accepts edge only after move done and position arrived
// - deferred mode sets acknowledge when a set-point is accepted
// - deferred mode clears acknowledge when bit 4 falls
// - deferred mode ignores set-points while busy, keeps active target
// - status low bits encode drive state, 0x37 pattern means running
`timescale 1ns/1ps
module pph_top
    import pph_pkg::*;
#(
    parameter int MS_CYC = MS_CYCLES
)(
    // clock and reset
    input  wire logic        mclk_i,
    input  wire logic        arst_n_i,
    // object dictionary access
    input  wire logic        od_wr_i,
    input  wire logic        od_rd_i,
    input  wire logic [15:0] od_index_i,
    input  wire logic [7:0]  od_sub_i,
    input  wire logic [31:0] od_wdata_i,
    output logic      [31:0] od_rdata_o,
    output logic             od_ack_o,
    // motion feedback
    input  wire logic        pg_busy_i,
    input  wire logic [31:0] pos_cmd_i,
    input  wire logic [31:0] pos_fb_i,
    input  wire logic [31:0] pos_act_i,
    input  wire logic [31:0] vel_act_i,
    input  wire logic [15:0] torque_act_i,
    // path generator command
    output logic             sp_start_o,
    output logic      [31:0] sp_target_o,
    output logic      [15:0] sp_vel_o,
    output logic      [15:0] sp_acc_o,
    output logic      [15:0] sp_dec_o,
    output logic             run_o,
    // status
    output logic      [15:0] status_word_o,
    output logic             pos_reached_o,
    output logic      [15:0] alarm_code_o
);

    pph_state_s q;
    pph_state_s d;

    logic        nsp;
    logic        nsp_rise;
    logic        nsp_fall;
    logic        immediate;
    logic        relative;
    logic        accept;
    logic [31:0] dev_abs;
    logic        in_band;
    logic        ms_tick;
    logic [31:0] new_end;

    function automatic logic [31:0] abs32(input logic [31:0] v);
        abs32 = v[31] ? (~v + 32'h0000_0001) : v;
    endfunction : abs32

    always_comb
    begin
        d = q;
        d.start = 1'b0;
        d.rack  = 1'b0;

        // register writes; read-only indices drop the write
        if (od_wr_i)
        begin
            case (od_index_i)
                IDX_CONTROL:  d.ctrl           = od_wdata_i[15:0];
                IDX_MODE_SEL: d.mode           = od_wdata_i[15:0];
                IDX_FE_LIMIT: d.fe_lim         = od_wdata_i[15:0];
                IDX_BAND:     d.band           = od_wdata_i;
                IDX_DWELL:    d.dwell          = od_wdata_i[15:0];
                IDX_TARGET:   d.host_sp.target = od_wdata_i;
                IDX_MOVE_VEL: d.host_sp.vel    = od_wdata_i[15:0];
                IDX_ACCEL:    d.host_sp.acc    = od_wdata_i[15:0];
                IDX_DECEL:    d.host_sp.dec    = od_wdata_i[15:0];
                IDX_TQ_FWD:   d.tq_fwd         = od_wdata_i[15:0];
                IDX_TQ_REV:   d.tq_rev         = od_wdata_i[15:0];
                IDX_GEAR:
                begin
                    if (od_sub_i == SUB_GEAR_NUM)
                    begin
                        d.gnum = od_wdata_i;
                    end
                    else if (od_sub_i == SUB_GEAR_DEN)
                    begin
                        d.gden = od_wdata_i;
                    end
                end
                default: ;
            endcase
        end

        // reads answer one cycle later; unknown indices read zero
        if (od_rd_i)
        begin
            d.rack = 1'b1;
            case (od_index_i)
                IDX_ERROR_CODE: d.rdata = {16'h0000, q.err_code};
                IDX_CONTROL:    d.rdata = {16'h0000, q.ctrl};
                IDX_STATUS:     d.rdata = {16'h0000, q.status};
                IDX_MODE_SEL:   d.rdata = {16'h0000, q.mode};
                IDX_MODE_DISP:  d.rdata = {16'h0000, q.mode};
                IDX_POS_CMD:    d.rdata = pos_cmd_i;
                IDX_POS_FB:     d.rdata = pos_fb_i;
                IDX_POS_ACT:    d.rdata = pos_act_i;
                IDX_FE_LIMIT:   d.rdata = {16'h0000, q.fe_lim};
                IDX_BAND:       d.rdata = q.band;
                IDX_DWELL:      d.rdata = {16'h0000, q.dwell};
                IDX_VEL_ACT:    d.rdata = vel_act_i;
                IDX_TORQUE_ACT: d.rdata = {16'h0000, torque_act_i};
                IDX_TARGET:     d.rdata = q.host_sp.target;
                IDX_MOVE_VEL:   d.rdata = {16'h0000, q.host_sp.vel};
                IDX_ACCEL:      d.rdata = {16'h0000, q.host_sp.acc};
                IDX_DECEL:      d.rdata = {16'h0000, q.host_sp.dec};
                IDX_TQ_FWD:     d.rdata = {16'h0000, q.tq_fwd};
                IDX_TQ_REV:     d.rdata = {16'h0000, q.tq_rev};
                IDX_DEVIATION:  d.rdata = q.dev;
                IDX_GEAR:
                begin
                    if (od_sub_i == SUB_GEAR_NUM)
                    begin
                        d.rdata = q.gnum;
                    end
                    else if (od_sub_i == SUB_GEAR_DEN)
                    begin
                        d.rdata = q.gden;
                    end
                    else
                    begin
                        d.rdata = 32'h0000_0000;
                    end
                end
                default:        d.rdata = 32'h0000_0000;
            endcase
        end

        // control word decode, working on the stored word
        d.run     = (q.ctrl[CW_RUN_MSB:CW_RUN_LSB] == CW_RUN_ALL);
        nsp       = q.ctrl[CW_NEW_SP];
        nsp_rise  = nsp & ~q.nsp_prev;
        nsp_fall  = ~nsp & q.nsp_prev;
        immediate = q.ctrl[CW_IMMEDIATE];
        relative  = q.ctrl[CW_RELATIVE];
        d.nsp_prev = nsp;

        // deferred mode waits for both the end of the move and arrival;
        // the host relies on the held acknowledge to see the edge was dropped
        accept = q.run & nsp_rise &
                 (immediate | (~pg_busy_i & q.reached));

        // relative adds to the active end point, so an unfinished move is
        // kept and the increments sum; absolute replaces it outright
        if (relative)
        begin
            new_end = q.act_sp.target + q.host_sp.target;
        end
        else
        begin
            new_end = q.host_sp.target;
        end

        if (accept)
        begin
            d.act_sp        = q.host_sp;
            d.act_sp.target = new_end;
            d.start         = 1'b1;
            d.sp_ack        = 1'b1;
        end
        else if (nsp_fall)
        begin
            d.sp_ack = 1'b0;
        end

        // deviation between path command and actual position
        d.dev   = pos_cmd_i - pos_act_i;
        dev_abs = abs32(q.dev);

        // following error holds for as long as the excess stays
        d.follow_err = (dev_abs > {16'h0000, q.fe_lim});
        d.err_code   = d.follow_err ? ALARM_FOLLOW : ALARM_NONE;

        // dwell timing in milliseconds while inside the band
        in_band = (dev_abs <= q.band) & ~pg_busy_i & ~accept;
        ms_tick = (q.ms_cnt == 32'(MS_CYC - 1));
        if (!in_band)
        begin
            d.ms_cnt    = 32'h0000_0000;
            d.dwell_cnt = 16'h0000;
            d.reached   = 1'b0;
        end
        else
        begin
            if (q.dwell_cnt >= q.dwell)
            begin
                d.reached = 1'b1;
                d.ms_cnt  = 32'h0000_0000;
            end
            else if (ms_tick)
            begin
                d.ms_cnt    = 32'h0000_0000;
                d.dwell_cnt = q.dwell_cnt + 16'h0001;
            end
            else
            begin
                d.ms_cnt = q.ms_cnt + 32'h0000_0001;
            end
        end

        // status word: state pattern plus the mode specific bits
        if (d.run)
        begin
            d.status = SW_OP_ENABLED;
        end
        else if (q.ctrl[CW_RUN_LSB])
        begin
            d.status = SW_READY;
        end
        else
        begin
            d.status = SW_IDLE;
        end
        d.status[SW_REACHED]    = d.reached;
        d.status[SW_SP_ACK]     = d.sp_ack;
        d.status[SW_FOLLOW_ERR] = d.follow_err;
    end

    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            q                <= '0;
            q.ctrl           <= RST_CTRL;
            q.mode           <= RST_MODE;
            q.fe_lim         <= RST_FE_LIM;
            q.band           <= RST_BAND;
            q.dwell          <= RST_DWELL;
            q.gnum           <= RST_GNUM;
            q.gden           <= RST_GDEN;
            q.tq_fwd         <= RST_TORQUE;
            q.tq_rev         <= RST_TORQUE;
            q.host_sp.target <= RST_TARGET;
            q.host_sp.vel    <= RST_VEL;
            q.host_sp.acc    <= RST_RAMP;
            q.host_sp.dec    <= RST_RAMP;
            q.act_sp.target  <= RST_TARGET;
            q.act_sp.vel     <= RST_VEL;
            q.act_sp.acc     <= RST_RAMP;
            q.act_sp.dec     <= RST_RAMP;
            q.status         <= SW_IDLE;
            q.err_code       <= ALARM_NONE;
        end
        else
        begin
            q <= d;
        end
    end

    // outputs straight from the state flops
    assign od_rdata_o    = q.rdata;
    assign od_ack_o      = q.rack;
    assign sp_start_o    = q.start;
    assign sp_target_o   = q.act_sp.target;
    assign sp_vel_o      = q.act_sp.vel;
    assign sp_acc_o      = q.act_sp.acc;
    assign sp_dec_o      = q.act_sp.dec;
    assign run_o         = q.run;
    assign status_word_o = q.status;
    assign pos_reached_o = q.reached;
    assign alarm_code_o  = q.err_code;

endmodule : pph_top

// [tb/pph_monitor.sv]
/*
 * pph_monitor: concurrent checks on the top ports of the set-point handshake.
 * assumes: bound to pph_top; one clock domain, asynchronous active-low reset.
 */
`timescale 1ns/1ps
module pph_monitor
    import pph_pkg::*;
(
    // clock and reset
    input  wire logic        mclk_i,
    input  wire logic        arst_n_i,
    // watched ports
    input  wire logic        pg_busy_i,
    input  wire logic        sp_start_o,
    input  wire logic [31:0] sp_target_o,
    input  wire logic        run_o,
    input  wire logic [15:0] status_word_o,
    input  wire logic        pos_reached_o,
    input  wire logic [15:0] alarm_code_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!arst_n_i);

    property p_run_state;
        run_o == (status_word_o[3:0] == 4'h7);
    endproperty
    a_run_state: assert property (p_run_state) else $error("run and state bits disagree");
    property p_reach_bit;
        pos_reached_o == status_word_o[10];
    endproperty
    a_reach_bit: assert property (p_reach_bit) else $error("reached output and bit differ");
    property p_ferr_alarm;
        alarm_code_o == (status_word_o[13] ? 16'h0009 : 16'h0000);
    endproperty
    a_ferr_alarm: assert property (p_ferr_alarm) else $error("alarm and error bit differ");
    property p_start_ack;
        sp_start_o |-> status_word_o[12];
    endproperty
    a_start_ack: assert property (p_start_ack) else $error("start without acknowledge");
    property p_start_pulse;
        sp_start_o |=> !sp_start_o;
    endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("start longer than one cycle");
    property p_target_hold;
        !sp_start_o |-> $stable(sp_target_o);
    endproperty
    a_target_hold: assert property (p_target_hold) else $error("target moved without start");
    property p_busy_no_reach;
        pg_busy_i ##1 pg_busy_i |-> !pos_reached_o;
    endproperty
    a_busy_no_reach: assert property (p_busy_no_reach) else $error("reached during move");
    property p_start_no_reach;
        sp_start_o |-> !status_word_o[10];
    endproperty
    a_start_no_reach: assert property (p_start_no_reach) else $error("reached at start");
    c_mid_move: cover property (sp_start_o && pg_busy_i);
    c_reached: cover property ($rose(pos_reached_o));
    c_ferr: cover property ($rose(status_word_o[13]));
endmodule : pph_monitor

bind pph_top pph_monitor u_pph_monitor (
    .mclk_i        (mclk_i),
    .arst_n_i      (arst_n_i),
    .pg_busy_i     (pg_busy_i),
    .sp_start_o    (sp_start_o),
    .sp_target_o   (sp_target_o),
    .run_o         (run_o),
    .status_word_o (status_word_o),
    .pos_reached_o (pos_reached_o),
    .alarm_code_o  (alarm_code_o)
);

// [tb/pph_motion.sv]
/*
 * pph_motion: path generator and axis stand-in behind the block.
 * assumes: same clock; the bench injects the deviation through off_i.
 */
`timescale 1ns/1ps
module pph_motion #(
    parameter int BUSY_CYC = 20
)(
    // clock and reset
    input  wire logic        mclk_i,
    input  wire logic        arst_n_i,
    // set-point from the block, offset from the bench
    input  wire logic        sp_start_i,
    input  wire logic [31:0] sp_target_i,
    input  wire logic [31:0] off_i,
    // feedback to the block
    output logic             pg_busy_o,
    output logic      [31:0] pos_cmd_o,
    output logic      [31:0] pos_act_o
);
    int cnt;
    // a fresh start restarts the move, so a mid-move accept keeps busy high
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            cnt       <= 0;
            pos_cmd_o <= 32'h0000_0000;
        end
        else if (sp_start_i)
        begin
            cnt       <= BUSY_CYC;
            pos_cmd_o <= sp_target_i;
        end
        else if (cnt != 0)
            cnt <= cnt - 1;
    end
    assign pg_busy_o = (cnt != 0);
    assign pos_act_o = pos_cmd_o - off_i;
endmodule : pph_motion

// [tb/tb.sv]
/*
 * tb: self-checking bench for pph_top with the motion stand-in.
 * assumes: MS_CYC shortened to 4; inputs change at the falling edge.
 */
`timescale 1ns/1ps
`define CHK(a, b) \
    begin \
        checked++; \
        if ((a) !== (b)) \
        begin \
            n_mismatch++; \
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); \
        end \
    end
module tb
    import pph_pkg::*;
;
    typedef struct packed {
        logic [15:0] idx;
        logic [7:0]  sub;
        logic [31:0] val;
    } pph_row_s;
    logic        mclk_i = 1'b0;
    logic        arst_n_i = 1'b0;
    logic        od_wr_i = 1'b0;
    logic        od_rd_i = 1'b0;
    logic [15:0] od_index_i = 16'h0000;
    logic [7:0]  od_sub_i = 8'h00;
    logic [31:0] od_wdata_i = 32'h0000_0000;
    logic [31:0] off = 32'h0000_0000;
    logic [31:0] od_rdata_o, sp_target_o, pos_cmd, pos_act;
    logic        od_ack_o, pg_busy, sp_start_o, run_o, pos_reached_o;
    logic [15:0] sp_vel_o, sp_acc_o, sp_dec_o, status_word_o, alarm_code_o;
    int          n_mismatch = 0;
    int          checked = 0;
    int          k;
    pph_row_s    rows [19] = '{
        '{16'h6040, 8'h00, 32'h0}, '{16'h6060, 8'h00, 32'h0}, '{16'h6061, 8'h00, 32'h0},
        '{16'h6065, 8'h00, 32'h7D00}, '{16'h6067, 8'h00, 32'hA}, '{16'h6068, 8'h00, 32'h0},
        '{16'h607A, 8'h00, 32'h0}, '{16'h6081, 8'h00, 32'h0}, '{16'h6083, 8'h00, 32'h64},
        '{16'h6084, 8'h00, 32'h64}, '{16'h6091, 8'h01, 32'h0}, '{16'h6091, 8'h02, 32'h2710},
        '{16'h60E0, 8'h00, 32'h64}, '{16'h60E1, 8'h00, 32'h64}, '{16'h603F, 8'h00, 32'h0},
        '{16'h6000, 8'h00, 32'h0}, '{16'h6091, 8'h03, 32'h0},
        '{16'h606C, 8'h00, 32'h0}, '{16'h6077, 8'h00, 32'h0}};

    always #2 mclk_i = ~mclk_i;

    pph_top #(.MS_CYC(4)) u_pph_top (
        .mclk_i(mclk_i), .arst_n_i(arst_n_i), .od_wr_i(od_wr_i), .od_rd_i(od_rd_i),
        .od_index_i(od_index_i), .od_sub_i(od_sub_i), .od_wdata_i(od_wdata_i),
        .od_rdata_o(od_rdata_o), .od_ack_o(od_ack_o), .pg_busy_i(pg_busy),
        .pos_cmd_i(pos_cmd), .pos_fb_i(pos_act), .pos_act_i(pos_act),
        .vel_act_i(32'h0000_0000), .torque_act_i(16'h0000), .sp_start_o(sp_start_o),
        .sp_target_o(sp_target_o), .sp_vel_o(sp_vel_o), .sp_acc_o(sp_acc_o),
        .sp_dec_o(sp_dec_o), .run_o(run_o), .status_word_o(status_word_o),
        .pos_reached_o(pos_reached_o), .alarm_code_o(alarm_code_o));
    pph_motion u_pph_motion (
        .mclk_i(mclk_i), .arst_n_i(arst_n_i), .sp_start_i(sp_start_o),
        .sp_target_i(sp_target_o), .off_i(off), .pg_busy_o(pg_busy),
        .pos_cmd_o(pos_cmd), .pos_act_o(pos_act));

    task automatic stop_test;
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : stop_test
    // one idle cycle first, so a back-to-back call never raises a strobe
    // in the same step in which the previous call lowered it
    task automatic wr(input logic [15:0] idx, input logic [31:0] d);
        @(negedge mclk_i);
        od_index_i = idx;
        od_sub_i = 8'h00;
        od_wdata_i = d;
        od_wr_i = 1'b1;
        @(negedge mclk_i);
        od_wr_i = 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] e);
        @(negedge mclk_i);
        od_index_i = idx;
        od_sub_i = sub;
        od_rd_i = 1'b1;
        @(negedge mclk_i);
        od_rd_i = 1'b0;
        `CHK(od_ack_o, 1'b1)
        `CHK(od_rdata_o, e)
    endtask : rd
    task automatic wt(input int w, input logic v);
        logic s;
        int   n;
        for (n = 0; n < 300; n++)
        begin
            @(negedge mclk_i);
            s = (w == 0) ? sp_start_o : (w == 1) ? pos_reached_o :
                (w == 2) ? pg_busy : status_word_o[13];
            if (s === v)
                break;
        end
        if (n == 300)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, s, v);
            stop_test();
        end
    endtask : wt
    task automatic quiet;
        repeat (12)
        begin
            @(negedge mclk_i);
            `CHK(sp_start_o, 1'b0)
        end
    endtask : quiet

    initial
    begin
        repeat (4) @(negedge mclk_i);
        `CHK(status_word_o, 16'h0250)
        `CHK(sp_acc_o, 16'h0064)
        arst_n_i = 1'b1;
        for (k = 0; k < 19; k++)
            rd(rows[k].idx, rows[k].sub, rows[k].val);
        wr(16'h603F, 32'h0000_0055);
        rd(16'h603F, 8'h00, 32'h0);
        // host loads the profile before any new set-point edge
        wr(16'h6081, 32'h0000_0005);
        wr(16'h6083, 32'h0000_0007);
        wr(16'h6084, 32'h0000_0009);
        rd(16'h6081, 8'h00, 32'h5);
        wr(16'h6040, 32'h0000_0007);
        wr(16'h6040, 32'h0000_0017);
        quiet();
        `CHK(run_o, 1'b0)
        `CHK(status_word_o, 16'h0631)
        wr(16'h6040, 32'h0000_000F);
        @(negedge mclk_i);
        `CHK(run_o, 1'b1)
        `CHK(status_word_o & 16'hFBFF, 16'h0237)
        rd(16'h6041, 8'h00, 32'h0000_0637);
        wr(16'h607A, 32'h0000_0064);
        wt(1, 1'b1);
        wr(16'h6040, 32'h0000_001F);
        wt(0, 1'b1);
        `CHK({sp_target_o, sp_vel_o, sp_acc_o, sp_dec_o}, 80'h64_0005_0007_0009)
        `CHK(status_word_o[12], 1'b1)
        wr(16'h607A, 32'h0000_012C);
        wr(16'h6040, 32'h0000_000F);
        @(negedge mclk_i);
        `CHK(status_word_o[12], 1'b0)
        wr(16'h6040, 32'h0000_001F);
        quiet();
        `CHK(sp_target_o, 32'h0000_0064)
        `CHK(status_word_o[12], 1'b0)
        wr(16'h6040, 32'h0000_000F);
        wt(2, 1'b0);
        wt(1, 1'b1);
        wr(16'h6040, 32'h0000_001F);
        wt(0, 1'b1);
        `CHK(sp_target_o, 32'h0000_012C)
        wr(16'h6040, 32'h0000_002F);
        wr(16'h607A, 32'h0000_01F4);
        wr(16'h6040, 32'h0000_003F);
        wt(0, 1'b1);
        `CHK({pg_busy, sp_target_o}, 33'h1_0000_01F4)
        wr(16'h6040, 32'h0000_002F);
        @(negedge mclk_i);
        `CHK(status_word_o[12], 1'b0)
        wr(16'h607A, 32'h0000_0258);
        wr(16'h6040, 32'h0000_003F);
        wt(0, 1'b1);
        `CHK(sp_target_o, 32'h0000_0258)
        wr(16'h6040, 32'h0000_006F);
        wr(16'h607A, 32'h0000_0032);
        wr(16'h6040, 32'h0000_007F);
        wt(0, 1'b1);
        `CHK(sp_target_o, 32'h0000_028A)
        wr(16'h6068, 32'h0000_0003);
        wr(16'h6040, 32'h0000_006F);
        wr(16'h6040, 32'h0000_007F);
        wt(0, 1'b1);
        `CHK(sp_target_o, 32'h0000_02BC)
        wt(2, 1'b1);
        wt(2, 1'b0);
        // dwell of 3 units at 4 cycles each cannot complete sooner
        for (k = 0; k < 100 && pos_reached_o !== 1'b1; k++)
            @(negedge mclk_i);
        `CHK(k >= 12 && k < 100, 1'b1)
        off = 32'h0000_0014;
        wt(1, 1'b0);
        `CHK(status_word_o[13], 1'b0)
        off = 32'h0000_8000;
        wt(3, 1'b1);
        `CHK(alarm_code_o, 16'h0009)
        rd(16'h603F, 8'h00, 32'h9);
        rd(16'h60F4, 8'h00, 32'h0000_8000);
        rd(16'h6062, 8'h00, 32'h0000_02BC);
        rd(16'h6064, 8'h00, 32'hFFFF_82BC);
        rd(16'h6063, 8'h00, 32'hFFFF_82BC);
        off = 32'h0000_0000;
        wt(3, 1'b0);
        wt(1, 1'b1);
        arst_n_i = 1'b0;
        @(negedge mclk_i);
        `CHK({run_o, sp_target_o, status_word_o}, 49'h0_0000_0000_0250)
        arst_n_i = 1'b1;
        @(negedge mclk_i);
        `CHK(run_o, 1'b0)
        stop_test();
    end
endmodule : tb
